// [hdl/mcuc_alu.sv]
/*
 * combinational alu of the core: result, zero and carry.
 * assumes the caller decides which flags it keeps.
 */
`timescale 1ns/10ps
module mcuc_alu
    import mcuc_pkg::*;
(
    input  wire mcuc_alu_op_t op,
    input  wire logic [7:0]   a,
    input  wire logic [7:0]   b,
    input  wire logic         c_in,
    output logic [7:0]        res,
    output logic              z,
    output logic              c
);
    logic [8:0] wide;

    always_comb
    begin
        wide = 9'h000;
        res  = a;
        c    = c_in;
        unique case (op)
            ALU_ADD:
            begin
                wide = {1'b0, a} + {1'b0, b};
                res  = wide[7:0];
                c    = wide[8];
            end
            ALU_SUB:
            begin
                // carry is the borrow
                wide = {1'b0, a} - {1'b0, b};
                res  = wide[7:0];
                c    = wide[8];
            end
            ALU_AND:
            begin
                res = a & b;
                c   = 1'b0;
            end
            ALU_INC: res = a + 8'h01;
            ALU_DEC: res = a - 8'h01;
            ALU_COM:
            begin
                res = ~a;
                c   = a[7];
            end
            ALU_RLC:
            begin
                res = {a[6:0], c_in};
                c   = a[7];
            end
            ALU_SLA:
            begin
                res = {a[6:0], 1'b0};
                c   = a[7];
            end
            ALU_CLR:
            begin
                res = 8'h00;
                c   = 1'b0;
            end
        endcase
        z = (res == 8'h00);
    end
endmodule : mcuc_alu

// [hdl/mcuc_core.sv]
/*
 * instruction sequencer of the 8-bit core: fetch, decode, execute.
 * assumes program and data memories answer combinationally in the
 * same cycle; wake, irq_save and watchdog_sel come from same-clock logic.
 */
`timescale 1ns/10ps
`include "mcuc_regs.svh"
module mcuc_core
    import mcuc_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        clk_en,
    output logic [11:0]      prog_addr,
    input  wire logic [7:0]  prog_rdata,
    output logic [7:0]       data_addr,
    input  wire logic [7:0]  data_rdata,
    output logic [7:0]       data_wdata,
    output logic             data_we,
    input  wire logic        watchdog_sel,
    input  wire logic        wake,
    input  wire logic        irq_save,
    output logic [7:0]       acc,
    output logic             result_null_flag,
    output logic             overflow_bit,
    output logic             wait_active,
    output logic             stop_active
);
    localparam int DEPTH = `MCUC_STACK_DEPTH;

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    logic [11:0]  pc_q, pc_d;
    logic [2:0]   cyc_q, cyc_d;
    logic [7:0]   op_q, op_d, b1_q, b1_d, b2_q, b2_d;
    logic [7:0]   ptr_q, ptr_d, opnd_q, opnd_d, acc_q, acc_d;
    logic         z_q, z_d, c_q, c_d, zs_q, zs_d, cs_q, cs_d;
    logic [7:0]   waddr_q, waddr_d, wdata_q, wdata_d;
    logic         we_q, we_d;
    mcuc_mode_t   mode_q, mode_d;
    logic [11:0]  stk_q [DEPTH];
    logic [11:0]  stk_d [DEPTH];
    logic         push, pop;

    // ------------------------------------------------------------------
    // decode
    // ------------------------------------------------------------------
    mcuc_kind_t   kind;
    mcuc_alu_op_t alu_op;
    mcuc_ea_t     ea;
    logic [2:0]   nbytes, ncyc;
    logic         imm, last, cond, tbit;
    logic [7:0]   ea_addr, rd_addr, alu_a, alu_b, alu_res, bmask;
    logic         alu_z, alu_c;
    logic [11:0]  rel_tgt, bt_tgt, jtarget;

    always_comb
    begin
        kind   = K_IDLE;
        alu_op = ALU_ADD;
        ea     = EA_NONE;
        nbytes = 3'h1;
        ncyc   = `MCUC_CYC_SHORT;
        imm    = 1'b0;
        if (!op_q[0])
            kind = K_REL;
        else
        begin
            unique case (op_q[3:0])
                `MCUC_LOW_CALL, `MCUC_LOW_JP:
                begin
                    kind   = op_q[3] ? K_JP : K_CALL;
                    nbytes = 3'h2;
                    ncyc   = `MCUC_CYC_ALU;
                end
                `MCUC_LOW_BTST:
                begin
                    kind   = K_BTST;
                    ea     = EA_DIR;
                    nbytes = 3'h3;
                    ncyc   = `MCUC_CYC_BIT;
                end
                `MCUC_LOW_BMOD:
                begin
                    kind   = K_BMOD;
                    ea     = EA_DIR;
                    nbytes = 3'h2;
                    ncyc   = `MCUC_CYC_ALU;
                end
                `MCUC_LOW_CNT:
                begin
                    kind   = K_RMW;
                    alu_op = op_q[5] ? ALU_DEC : ALU_INC;
                    ea     = EA_SHORT;
                    ncyc   = `MCUC_CYC_ALU;
                end
                `MCUC_LOW_IND, `MCUC_LOW_DIR:
                begin
                    ncyc   = `MCUC_CYC_ALU;
                    nbytes = op_q[4] ? 3'h2 : 3'h1;
                    unique case (op_q[7:5])
                        3'h0: alu_op = ALU_ADD;
                        3'h1: alu_op = ALU_SUB;
                        3'h2: alu_op = ALU_SUB;
                        3'h3: alu_op = ALU_AND;
                        3'h4: alu_op = ALU_INC;
                        3'h5: alu_op = ALU_DEC;
                        default: alu_op = ALU_ADD;
                    endcase
                    unique case (op_q[7:5])
                        3'h2: kind = K_CP;
                        3'h4, 3'h5: kind = K_RMW;
                        3'h6, 3'h7: kind = K_IDLE;
                        default: kind = K_ACC;
                    endcase
                    if (op_q[3:0] == `MCUC_LOW_DIR)
                        ea = op_q[4] ? EA_DIR : EA_IND_Y;
                    else if (!op_q[4])
                        ea = EA_IND_X;
                    else if (kind == K_RMW)
                        ea = EA_DIR;
                    else
                        imm = 1'b1;
                    if (kind == K_IDLE)
                        ncyc = `MCUC_CYC_SHORT;
                end
                `MCUC_LOW_INH:
                begin
                    ncyc = `MCUC_CYC_ALU;
                    unique case (op_q[7:4])
                        `MCUC_INH_COM: alu_op = ALU_COM;
                        `MCUC_INH_RLC: alu_op = ALU_RLC;
                        `MCUC_INH_SLA: alu_op = ALU_SLA;
                        default:       alu_op = ALU_CLR;
                    endcase
                    unique case (op_q[7:4])
                        `MCUC_INH_COM, `MCUC_INH_RLC: kind = K_ACC;
                        `MCUC_INH_SLA, `MCUC_INH_CLRA:
                        begin
                            kind   = K_ACC;
                            nbytes = 3'h2;
                        end
                        `MCUC_INH_CLRM:
                        begin
                            kind   = K_CLRM;
                            ea     = EA_DIR;
                            nbytes = 3'h3;
                        end
                        `MCUC_INH_RET:  kind = K_RET;
                        `MCUC_INH_INTERRUPT_RETURN: kind = K_INTERRUPT_RETURN;
                        `MCUC_INH_STOP: kind = K_STOP;
                        `MCUC_INH_WAIT: kind = K_WAIT;
                        default:        kind = K_IDLE;
                    endcase
                    if (kind inside {K_IDLE, K_RET, K_INTERRUPT_RETURN, K_STOP, K_WAIT})
                        ncyc = `MCUC_CYC_SHORT;
                end
                default: kind = K_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // operands and targets
    // ------------------------------------------------------------------
    always_comb
    begin
        unique case (ea)
            EA_SHORT: ea_addr = {`MCUC_SHORT_BASE, op_q[7:6]};
            EA_IND_X, EA_IND_Y: ea_addr = ptr_q;
            default:  ea_addr = b1_q;
        endcase
        if (cyc_q == 3'h1 && ea == EA_IND_X)
            rd_addr = `MCUC_PTR_X;
        else if (cyc_q == 3'h1 && ea == EA_IND_Y)
            rd_addr = `MCUC_PTR_Y;
        else
            rd_addr = ea_addr;
        unique case (op_q[2:1])
            2'h0: cond = !z_q;
            2'h1: cond = !c_q;
            2'h2: cond = z_q;
            2'h3: cond = c_q;
        endcase
    end

    // accumulator is always one side, except for the count ops
    assign alu_a   = (kind == K_RMW) ? opnd_q : acc_q;
    assign alu_b   = imm ? b1_q : opnd_q;
    assign tbit    = opnd_q[op_q[7:5]];
    assign bmask   = 8'h01 << op_q[7:5];
    assign rel_tgt = pc_q + {{7{op_q[7]}}, op_q[7:3]};
    assign bt_tgt  = pc_q + `MCUC_BT_BIAS + {{4{b2_q[7]}}, b2_q};
    assign jtarget = {op_q[7:4], b1_q};
    assign last    = (cyc_q != 3'h0) && (cyc_q == ncyc - 3'h1);

    mcuc_alu u_alu (
        .op   (alu_op),
        .a    (alu_a),
        .b    (alu_b),
        .c_in (c_q),
        .res  (alu_res),
        .z    (alu_z),
        .c    (alu_c)
    );

    // ------------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------------
    always_comb
    begin
        {pc_d, cyc_d, op_d, b1_d, b2_d} = {pc_q, cyc_q, op_q, b1_q, b2_q};
        {ptr_d, opnd_d, acc_d, z_d, c_d} = {ptr_q, opnd_q, acc_q, z_q, c_q};
        {waddr_d, wdata_d} = {waddr_q, wdata_q};
        mode_d = mode_q;
        we_d = 1'b0;
        push = 1'b0;
        pop  = 1'b0;
        zs_d = irq_save ? z_q : zs_q;
        cs_d = irq_save ? c_q : cs_q;
        if (mode_q != MODE_RUN)
        begin
            if (wake)
                mode_d = MODE_RUN;
        end
        else
        begin
            cyc_d = last ? 3'h0 : cyc_q + 3'h1;
            if (cyc_q == 3'h0)
            begin
                op_d = prog_rdata;
                pc_d = pc_q + 12'h001;
            end
            else if (cyc_q < nbytes)
            begin
                if (cyc_q == 3'h1)
                    b1_d = prog_rdata;
                else
                    b2_d = prog_rdata;
                pc_d = pc_q + 12'h001;
            end
            if (cyc_q == 3'h1 && (ea == EA_IND_X || ea == EA_IND_Y))
                ptr_d = data_rdata;
            if (cyc_q != 3'h0 && cyc_q == ncyc - 3'h2)
                opnd_d = data_rdata;
            if (last)
            begin
                unique case (kind)
                    K_REL: if (cond) pc_d = rel_tgt;
                    K_JP:  pc_d = jtarget;
                    K_CALL:
                    begin
                        pc_d = jtarget;
                        push = 1'b1;
                    end
                    K_BTST:
                    begin
                        c_d = tbit;
                        if (tbit == op_q[4])
                            pc_d = bt_tgt;
                    end
                    K_BMOD:
                    begin
                        we_d    = 1'b1;
                        waddr_d = ea_addr;
                        wdata_d = op_q[4] ? (opnd_q | bmask)
                                          : (opnd_q & ~bmask);
                    end
                    K_ACC:
                    begin
                        acc_d = alu_res;
                        z_d   = alu_z;
                        c_d   = alu_c;
                    end
                    K_CP:
                    begin
                        z_d = alu_z;
                        c_d = alu_c;
                    end
                    K_RMW:
                    begin
                        we_d    = 1'b1;
                        waddr_d = ea_addr;
                        wdata_d = alu_res;
                        z_d     = alu_z;
                    end
                    K_CLRM:
                    begin
                        we_d    = 1'b1;
                        waddr_d = ea_addr;
                        wdata_d = 8'h00;
                    end
                    K_RET:
                    begin
                        pc_d = stk_q[0];
                        pop  = 1'b1;
                    end
                    K_INTERRUPT_RETURN:
                    begin
                        pc_d = stk_q[0];
                        pop  = 1'b1;
                        z_d  = zs_q;
                        c_d  = cs_q;
                    end
                    K_STOP: mode_d = watchdog_sel ? MODE_WAIT
                                                  : MODE_STOP;
                    K_WAIT: mode_d = MODE_WAIT;
                    K_IDLE: mode_d = mode_q;
                endcase
            end
        end
    end

    // ------------------------------------------------------------------
    // return stack, oldest entry dropped on overflow
    // ------------------------------------------------------------------
    for (genvar g = 0; g < DEPTH; g++)
    begin : g_stk
        if (g == DEPTH - 1)
        begin : g_bot
            assign stk_d[g] = push ? stk_q[g - 1] : stk_q[g];
        end
        else if (g == 0)
        begin : g_top
            assign stk_d[g] = push ? pc_q : (pop ? stk_q[1] : stk_q[0]);
        end
        else
        begin : g_mid
            assign stk_d[g] = push ? stk_q[g - 1]
                                   : (pop ? stk_q[g + 1] : stk_q[g]);
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pc_q <= `MCUC_PC_RST;
            cyc_q <= 3'h0;
            {op_q, b1_q, b2_q, ptr_q} <= {4{`MCUC_BYTE_RST}};
            {opnd_q, acc_q, waddr_q, wdata_q} <= {4{`MCUC_BYTE_RST}};
            {z_q, c_q, zs_q, cs_q, we_q} <= 5'h00;
            mode_q <= MODE_RUN;
            for (int i = 0; i < DEPTH; i++)
                stk_q[i] <= `MCUC_PC_RST;
        end
        else if (clk_en)
        begin
            {pc_q, cyc_q, op_q, b1_q, b2_q} <= {pc_d, cyc_d, op_d, b1_d, b2_d};
            {ptr_q, opnd_q, acc_q, z_q, c_q} <= {ptr_d, opnd_d, acc_d, z_d, c_d};
            {waddr_q, wdata_q, we_q} <= {waddr_d, wdata_d, we_d};
            {zs_q, cs_q} <= {zs_d, cs_d};
            mode_q <= mode_d;
            for (int i = 0; i < DEPTH; i++)
                stk_q[i] <= stk_d[i];
        end
    end

    // write is issued one cycle after execute, so it overlaps next fetch
    assign prog_addr        = pc_q;
    assign data_addr        = we_q ? waddr_q : rd_addr;
    assign data_wdata       = wdata_q;
    assign data_we          = we_q;
    assign acc              = acc_q;
    assign result_null_flag = z_q;
    assign overflow_bit     = c_q;
    assign wait_active      = (mode_q == MODE_WAIT);
    assign stop_active      = (mode_q == MODE_STOP);

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    logic fetch, exec;
    assign fetch = (mode_q == MODE_RUN) && (cyc_q == 3'h0);
    assign exec  = (mode_q == MODE_RUN) && last;

    a_rel_length: assert property (@(posedge clk) disable iff (!rst_n || !clk_en)
        fetch && !prog_rdata[0] |=> (cyc_q != 3'h0) ##1 (cyc_q == 3'h0))
        else $error("short branch not 2 cycles");
    a_rel_flags: assert property (@(posedge clk) disable iff (!rst_n || !clk_en)
        fetch && !prog_rdata[0] |-> ##2 (z_q == $past(z_q, 2)) && (c_q == $past(c_q, 2)))
        else $error("short branch changed flags");
    a_alu_length: assert property (@(posedge clk) disable iff (!rst_n || !clk_en)
        fetch && prog_rdata[3:0] == `MCUC_LOW_IND && prog_rdata[7:6] != 2'h3
        |=> (cyc_q != 3'h0) [*3] ##1 (cyc_q == 3'h0))
        else $error("alu op not 4 cycles");
    a_bit_length: assert property (@(posedge clk) disable iff (!rst_n || !clk_en)
        fetch && prog_rdata[3:0] == `MCUC_LOW_BTST
        |=> (cyc_q != 3'h0) [*4] ##1 (cyc_q == 3'h0))
        else $error("bit-test branch not 5 cycles");
    a_bit_carry: assert property (@(posedge clk) disable iff (!rst_n || !clk_en)
        exec && kind == K_BTST |=> (c_q == $past(tbit)) && $stable(z_q))
        else $error("tested bit not copied to carry");
    a_count_carry: assert property (@(posedge clk) disable iff (!rst_n || !clk_en)
        exec && kind == K_RMW |=> $stable(c_q) && data_we)
        else $error("count op touched carry");
    a_stop_wait: assert property (@(posedge clk) disable iff (!rst_n || !clk_en)
        exec && kind == K_STOP && watchdog_sel |=> wait_active && !stop_active)
        else $error("stop not turned into wait");
    a_bit_write: assert property (@(posedge clk) disable iff (!rst_n || !clk_en)
        exec && kind == K_BMOD |=> data_we && data_addr == $past(b1_q)
        && $stable(z_q) && $stable(c_q))
        else $error("bit set/clear write wrong");
    a_long_target: assert property (@(posedge clk) disable iff (!rst_n || !clk_en)
        exec && (kind == K_JP || kind == K_CALL) |=> pc_q == $past(jtarget))
        else $error("long jump target wrong");
    a_rel_next: assert property (@(posedge clk) disable iff (!rst_n || !clk_en)
        exec && kind == K_REL && !cond |=> pc_q == $past(pc_q))
        else $error("false branch did not fall through");
endmodule : mcuc_core

// [pkg/mcuc_pkg.sv]
/*
 * types shared by the core sequencer and its alu.
 * assumes nothing of its surroundings.
 */
package mcuc_pkg;
    typedef enum logic [3:0] {
        ALU_ADD, ALU_SUB, ALU_AND, ALU_INC, ALU_DEC,
        ALU_COM, ALU_RLC, ALU_SLA, ALU_CLR
    } mcuc_alu_op_t;
    typedef enum logic [3:0] {
        K_IDLE, K_REL, K_JP, K_CALL, K_BTST, K_BMOD, K_ACC, K_CP,
        K_RMW, K_CLRM, K_RET, K_INTERRUPT_RETURN, K_STOP, K_WAIT
    } mcuc_kind_t;
    typedef enum logic [2:0] {
        EA_NONE, EA_SHORT, EA_IND_X, EA_IND_Y, EA_DIR
    } mcuc_ea_t;
    typedef enum logic [1:0] {
        MODE_RUN, MODE_WAIT, MODE_STOP
    } mcuc_mode_t;
endpackage : mcuc_pkg

// [pkg/mcuc_regs.svh]
/*
 * constants of the small 8-bit core sequencer: opcode classes, cycle
 * counts, data-space locations of the short registers, reset values.
 * assumes it is included once per compile unit by its bare name.
 */
`ifndef MCUC_REGS_SVH
`define MCUC_REGS_SVH

// ----------------------------------------------------------------------
// opcode classes (low nibble; even opcodes are short branches)
// ----------------------------------------------------------------------
`define MCUC_LOW_CALL 4'h1
`define MCUC_LOW_JP   4'h9
`define MCUC_LOW_BTST 4'h3
`define MCUC_LOW_BMOD 4'hB
`define MCUC_LOW_CNT  4'h5
`define MCUC_LOW_IND  4'h7
`define MCUC_LOW_DIR  4'hF
`define MCUC_LOW_INH  4'hD
// inherent group, high nibble
`define MCUC_INH_IDLE 4'h0
`define MCUC_INH_COM  4'h1
`define MCUC_INH_RLC  4'h2
`define MCUC_INH_SLA  4'h3
`define MCUC_INH_RET  4'h4
`define MCUC_INH_INTERRUPT_RETURN 4'h5
`define MCUC_INH_STOP 4'h6
`define MCUC_INH_WAIT 4'h7
`define MCUC_INH_CLRA 4'h8
`define MCUC_INH_CLRM 4'h9

// ----------------------------------------------------------------------
// cycle counts, locations, reset values
// ----------------------------------------------------------------------
`define MCUC_CYC_SHORT 3'h2
`define MCUC_CYC_ALU   3'h4
`define MCUC_CYC_BIT   3'h5
`define MCUC_SHORT_BASE 6'h20
`define MCUC_PTR_X     8'h80
`define MCUC_PTR_Y     8'h81
`define MCUC_BT_BIAS   12'hFFF
`define MCUC_STACK_DEPTH 6
`define MCUC_PC_RST    12'h000
`define MCUC_BYTE_RST  8'h00
`endif

// [tb/mcuc_core_tb.sv]
/*
 * bench for the core sequencer: runs three short programs and checks them.
 * assumes the memory model answers in the same cycle.
 */
`timescale 1ns/10ps
module mcuc_core_tb;
    logic        clk, rst_n, wake, wdog, we, zf, cf, wt, st, irqs;
    logic [11:0] pa;
    logic [7:0]  pd, da, dd, dw, acc;
    int          n_fail, cmp_count, cyc;
    // skipped slots hold zero_fill acc, so a wrong branch shows in acc
    logic [7:0]  p1 [14] = '{8'h17, 8'h05, 8'h5B, 8'h40, 8'h53, 8'h40,
        8'h02, 8'h8D, 8'h16, 8'h8D, 8'h8D, 8'h04, 8'h19, 8'h00};
    // shift, counts, and, call/interrupt_return, bit test, compare, clear
    logic [7:0]  p3 [23] = '{8'h3D, 8'h00, 8'hE5, 8'hC5, 8'h77, 8'h0F,
        8'h21, 8'h40, 8'h0E, 8'h8D, 8'h0C, 8'h8D, 8'h05, 8'h87, 8'h13,
        8'h83, 8'h7F, 8'h57, 8'h04, 8'h9D, 8'h80, 8'h00, 8'h7D};
    mcuc_core u_mcuc_core (.clk(clk), .rst_n(rst_n), .clk_en(1'b1),
        .prog_addr(pa), .prog_rdata(pd), .data_addr(da), .data_rdata(dd),
        .data_wdata(dw), .data_we(we), .watchdog_sel(wdog), .wake(wake),
        .irq_save(irqs), .acc(acc), .result_null_flag(zf),
        .overflow_bit(cf), .wait_active(wt), .stop_active(st));
    mcuc_mem u_mcuc_mem (.clk(clk), .prog_addr(pa), .prog_rdata(pd),
        .data_addr(da), .data_rdata(dd), .data_wdata(dw), .data_we(we));
    task automatic check(string nm, logic [11:0] seen, logic [11:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check
    task automatic results();
        $display("mismatches %0d compares %0d", n_fail, cmp_count);
        if (n_fail == 0 && cmp_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : results
    task automatic halt_wait(input logic which, output int n);
        n = 0;
        while ((which ? st : wt) !== 1'b1 && n < 100)
        begin
            @(negedge clk);
            n++;
        end
    endtask : halt_wait
    // add imm, bit set, bit test, carry branch, false zero branch, jump
    task automatic run_branches();
        int n;
        halt_wait(1'b0, n);
        check("cycles", 12'(n), 12'd23);
        check("acc", {4'h0, acc}, 12'h005);
        check("bit", {4'h0, u_mcuc_mem.data[8'h40]}, 12'h004);
        check("carry", {11'h0, cf}, 12'h001);
        check("zero", {11'h0, zf}, 12'h000);
        check("stop", {11'h0, st}, 12'h000);
        check("pc", pa, 12'h101);
    endtask : run_branches
    task automatic run_invert();
        int n;
        wdog = 1'b0;
        wake = 1'b1;
        @(negedge clk);
        wake = 1'b0;
        halt_wait(1'b1, n);
        check("inv", {4'h0, acc}, 12'h0FA);
        check("inv_c", {11'h0, cf}, 12'h000);
        check("stopped", {10'h0, st, wt}, 12'h002);
    endtask : run_invert
    // shadow taken while flags are set, restored after they were cleared
    task automatic run_shadow();
        int n, m;
        wake = 1'b1;
        @(negedge clk);
        wake = 1'b0;
        n = 0;
        while (zf !== 1'b1 && n < 100)
        begin
            @(negedge clk);
            n++;
        end
        irqs = 1'b1;
        @(negedge clk);
        irqs = 1'b0;
        halt_wait(1'b0, m);
        check("cycles3", 12'(n + m + 1), 12'd53);
        check("acc3", {4'h0, acc}, 12'h004);
        check("zero3", {11'h0, zf}, 12'h001);
        check("carry3", {11'h0, cf}, 12'h000);
        check("short", {4'h0, u_mcuc_mem.data[8'h83]}, 12'h000);
        check("ind", {4'h0, u_mcuc_mem.data[8'h01]}, 12'h001);
        check("clr", {4'h0, u_mcuc_mem.data[8'h80]}, 12'h000);
        check("pc3", pa, 12'h217);
    endtask : run_shadow
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // a hang past this ceiling is cut short
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 2000)
        begin
            n_fail++;
            results();
        end
    end
    initial
    begin
        rst_n = 1'b0;
        wake = 1'b0;
        wdog = 1'b1;
        irqs = 1'b0;
        for (int i = 0; i < 4096; i++)
            u_mcuc_mem.prog[i] = (i < 14) ? p1[i] : 8'h8D;
        for (int i = 0; i < 256; i++)
            u_mcuc_mem.data[i] = 8'h00;
        u_mcuc_mem.prog[12'h100] = 8'h6D;
        u_mcuc_mem.prog[12'h101] = 8'h1D;
        u_mcuc_mem.prog[12'h102] = 8'h6D;
        u_mcuc_mem.prog[12'h103] = 8'h29;
        u_mcuc_mem.prog[12'h104] = 8'h00;
        u_mcuc_mem.prog[12'h240] = 8'h5D;
        for (int i = 0; i < 23; i++)
            u_mcuc_mem.prog[12'h200 + i] = p3[i];
        repeat (8) @(negedge clk);
        rst_n = 1'b1;
        run_branches();
        run_invert();
        run_shadow();
        results();
    end
endmodule : mcuc_core_tb

// [tb/mcuc_mem.sv]
/*
 * program and data memory model for the core sequencer.
 * assumes one clock and reads answered in the same cycle.
 */
`timescale 1ns/10ps
module mcuc_mem
(
    input  wire logic        clk,
    input  wire logic [11:0] prog_addr,
    output logic [7:0]       prog_rdata,
    input  wire logic [7:0]  data_addr,
    output logic [7:0]       data_rdata,
    input  wire logic [7:0]  data_wdata,
    input  wire logic        data_we
);
    logic [7:0] prog [4096];
    logic [7:0] data [256];
    // immediate bytes live in program space
    assign prog_rdata = prog[prog_addr];
    assign data_rdata = data[data_addr];
    always @(posedge clk)
    begin
        if (data_we)
            data[data_addr] <= data_wdata;
    end
endmodule : mcuc_mem
